// ===== logic/kms_scanner.sv
// Purpose: key matrix scanner with serial key read-back and power save
// Assumes: serial link pins are sampled by clk, far slower than clk
// Notes:   control bits live in an AXI4-Lite register file
//
// Register access over AXI4-Lite and the register offsets were decided locally.

// Overview of operation
// - key read selected by address 43h shifted in before data out
// - 30 key bits, index (row-1)*5+column, 1 when pressed
// - acknowledge bit is 1 in power save, 0 in normal mode
// - any power-save bit set: LCD outputs blanked and oscillator stopped while the sequencer is idle
// - power save ends only when all three bits are written zero
// - general-purpose outputs keep working in power save
// - one scan lasts 4608 oscillator periods
// - two agreeing scans give request low 9840 periods after start
// - disagreeing scans with key held rescan, worst case 19680 periods
// - in normal mode idle scan outputs sit high
// - scanning repeats until release; several bits may be set together
// - request line released while chip enable is high
// - after a key read the request clears and a new scan starts
// - in power save rows follow control bits; low rows never scan
// - press on a high row in power save wakes and scans only the rows left high
// - key read in power save does not leave power save
// - request/data line is open drain, only pulls low
// - after reset all three power-save bits are one
module kms_scanner #(
  parameter int unsigned SCAN_LEN = kms_pkg::SCAN_CYC,
  parameter int unsigned REQ_LEN  = kms_pkg::REQ_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_clock_in,
  input  wire logic        chip_enable_in,
  input  wire logic        serial_data_in,
  output logic             serial_out_key_request,
  output logic             serial_out_key_request_oe,
  output logic [5:0]       scan_row_outputs,
  input  wire logic [4:0]  return_column_inputs,
  output logic             lcd_outputs_off,
  output logic             osc_running,
  output logic [8:0]       gpo_outputs
);
  localparam int unsigned ROW_LEN  = SCAN_LEN / kms_pkg::NUM_ROWS;
  localparam int unsigned NK       = kms_pkg::NUM_KEYS;
  localparam logic [2:0]  LAST_ROW = 3'(kms_pkg::NUM_ROWS - 1);

  // register map decode, shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    if (a == kms_pkg::OFS_CTRL) reg_sel = 2'h0;
    else if (a == kms_pkg::OFS_STATUS) reg_sel = 2'h1;
    else if (a == kms_pkg::OFS_KEYS) reg_sel = 2'h2;
    else reg_sel = 2'h3;
  endfunction

  // rows left high in power save; code 7 parks every row low
  function automatic logic [5:0] ps_rows(input logic [2:0] c);
    logic [5:0] m;
    m = '0;
    for (int i = 0; i < 6; i++) begin
      if (c != 3'h7 && 3'(5 - i) < c) m[i] = 1'b1;
    end
    ps_rows = m;
  endfunction

  // ports 1..sel are general-purpose, code 7 selects all nine
  function automatic logic [8:0] port_en(input logic [2:0] s);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++) begin
      if (s == 3'h7 || 4'(i) < {1'b0, s}) m[i] = 1'b1;
    end
    port_en = m;
  endfunction

  logic [2:0]  ps_ctl_q, ps_ctl_d;
  logic [2:0]  psel_q, psel_d;
  logic [8:0]  gpo_q, gpo_d;
  logic        awr_d, wr_d, bv_d, arr_d, rv_d;
  logic [1:0]  br_d, rr_d;
  logic [31:0] rdat_d, wimg;
  kms_pkg::kms_state_t st_q, st_d;
  logic [13:0] cnt_q, cnt_d, slot_q, slot_d;
  logic [2:0]  row_q, row_d;
  logic        pass_q, pass_d;
  logic [NK-1:0] img1_q, img1_d, img2_q, img2_d, key_q, key_d;
  logic [5:0]  rows_d;
  logic [4:0]  cols;
  logic [2:0]  link_s;
  logic        scl_s, ce_s, sdi_s, scl_p, ce_p;
  logic [7:0]  addr_q, addr_d;
  logic        rd_q, rd_d, oe_d, read_done;
  logic [NK:0] shf_q, shf_d;
  logic        ps_on;
  logic [5:0]  live_rows;

  assign ps_on     = |ps_ctl_q;
  assign live_rows = ps_on ? ps_rows(ps_ctl_q) : 6'h3f;

  kms_sync #(.W(5)) u_cols (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .async_in   (return_column_inputs),
    .stable_out (cols)
  );

  kms_sync #(.W(3)) u_link (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .async_in   ({serial_data_in, chip_enable_in, serial_clock_in}),
    .stable_out (link_s)
  );
  assign {sdi_s, ce_s, scl_s} = link_s;

  // bus slave: write taken when address and data are both offered
  always_comb begin
    awr_d    = 1'b0;
    wr_d     = 1'b0;
    arr_d    = 1'b0;
    bv_d     = s_axi_bvalid & ~s_axi_bready;
    br_d     = s_axi_bresp;
    rv_d     = s_axi_rvalid & ~s_axi_rready;
    rr_d     = s_axi_rresp;
    rdat_d   = s_axi_rdata;
    ps_ctl_d = ps_ctl_q;
    psel_d   = psel_q;
    gpo_d    = gpo_q;
    wimg     = '0;
    wimg[kms_pkg::CTL_PS_LSB +: 3]   = ps_ctl_q;
    wimg[kms_pkg::CTL_PSEL_LSB +: 3] = psel_q;
    wimg[kms_pkg::CTL_GPO_LSB +: 9]  = gpo_q;
    if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
        !s_axi_bvalid) begin
      awr_d = 1'b1;
      wr_d  = 1'b1;
    end
    if (s_axi_awready) begin
      bv_d = 1'b1;
      br_d = kms_pkg::RESP_OKAY;
      unique case (reg_sel(s_axi_awaddr))
        2'h0: begin
          for (int i = 0; i < 4; i++) begin
            if (s_axi_wstrb[i]) wimg[8*i +: 8] = s_axi_wdata[8*i +: 8];
          end
          ps_ctl_d = wimg[kms_pkg::CTL_PS_LSB +: 3];
          psel_d   = wimg[kms_pkg::CTL_PSEL_LSB +: 3];
          gpo_d    = wimg[kms_pkg::CTL_GPO_LSB +: 9];
        end
        2'h1, 2'h2: br_d = kms_pkg::RESP_OKAY; // read-only, write dropped
        2'h3: br_d = kms_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) arr_d = 1'b1;
    if (s_axi_arready) begin
      rv_d   = 1'b1;
      rr_d   = kms_pkg::RESP_OKAY;
      rdat_d = '0;
      unique case (reg_sel(s_axi_araddr))
        2'h0: rdat_d = wimg;
        2'h1: begin
          rdat_d[kms_pkg::ST_ACK_BIT]  = ps_on;
          rdat_d[kms_pkg::ST_REQ_BIT]  = (st_q == kms_pkg::SC_REQ);
          rdat_d[kms_pkg::ST_BUSY_BIT] = (st_q != kms_pkg::SC_IDLE);
        end
        2'h2: rdat_d[NK-1:0] = key_q;
        2'h3: rr_d = kms_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= kms_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= kms_pkg::RESP_OKAY;
      s_axi_rdata   <= '0;
      ps_ctl_q      <= kms_pkg::PS_RST;
      psel_q        <= kms_pkg::PSEL_RST;
      gpo_q         <= kms_pkg::GPO_RST;
    end else begin
      s_axi_awready <= awr_d;
      s_axi_wready  <= wr_d;
      s_axi_bvalid  <= bv_d;
      s_axi_bresp   <= br_d;
      s_axi_arready <= arr_d;
      s_axi_rvalid  <= rv_d;
      s_axi_rresp   <= rr_d;
      s_axi_rdata   <= rdat_d;
      ps_ctl_q      <= ps_ctl_d;
      psel_q        <= psel_d;
      gpo_q         <= gpo_d;
    end
  end

  // scan sequencer: two passes, a tail to the request point, compare
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 14'h0001;
    slot_d = slot_q;
    row_d  = row_q;
    pass_d = pass_q;
    img1_d = img1_q;
    img2_d = img2_q;
    key_d  = key_q;
    unique case (st_q)
      kms_pkg::SC_IDLE: begin
        cnt_d = '0;
        // only high rows can raise a column, so low rows never wake
        if (|cols) begin
          st_d   = kms_pkg::SC_SCAN;
          slot_d = '0;
          row_d  = '0;
          pass_d = 1'b0;
          img1_d = '0;
          img2_d = '0;
        end
      end
      kms_pkg::SC_SCAN: begin
        slot_d = slot_q + 14'h0001;
        // sample late in the slot so the synchroniser has settled
        if (slot_q == 14'(ROW_LEN - 1)) begin
          slot_d = '0;
          if (pass_q) img2_d[row_q*5 +: 5] = cols;
          else img1_d[row_q*5 +: 5] = cols;
          if (row_q == LAST_ROW) begin
            row_d  = '0;
            pass_d = 1'b1;
            if (pass_q) st_d = kms_pkg::SC_TAIL;
          end else begin
            row_d = row_q + 3'h1;
          end
        end
      end
      kms_pkg::SC_TAIL: begin
        if (cnt_q == 14'(REQ_LEN - 1)) begin
          if (img1_q == img2_q && |img1_q) begin
            st_d  = kms_pkg::SC_REQ;
            key_d = img1_q;
          end else if (|img1_q || |img2_q) begin
            st_d   = kms_pkg::SC_SCAN;
            cnt_d  = '0;
            pass_d = 1'b0;
            img1_d = '0;
            img2_d = '0;
          end else begin
            st_d = kms_pkg::SC_IDLE;
          end
        end
      end
      kms_pkg::SC_REQ: begin
        cnt_d = '0;
        if (read_done) begin
          st_d   = kms_pkg::SC_SCAN;
          slot_d = '0;
          row_d  = '0;
          pass_d = 1'b0;
          img1_d = '0;
          img2_d = '0;
        end
      end
      default: st_d = kms_pkg::SC_IDLE;
    endcase
    // one row high at a time while scanning, else idle level
    rows_d = live_rows;
    if (st_d == kms_pkg::SC_SCAN) begin
      rows_d = (6'h01 << row_d) & live_rows;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q             <= kms_pkg::SC_IDLE;
      cnt_q            <= '0;
      slot_q           <= '0;
      row_q            <= '0;
      pass_q           <= 1'b0;
      img1_q           <= '0;
      img2_q           <= '0;
      key_q            <= '0;
      scan_row_outputs <= '0;
      lcd_outputs_off  <= 1'b1;
      osc_running      <= 1'b0;
      gpo_outputs      <= '0;
    end else begin
      st_q             <= st_d;
      cnt_q            <= cnt_d;
      slot_q           <= slot_d;
      row_q            <= row_d;
      pass_q           <= pass_d;
      img1_q           <= img1_d;
      img2_q           <= img2_d;
      key_q            <= key_d;
      scan_row_outputs <= rows_d;
      lcd_outputs_off  <= ps_on;
      osc_running      <= ~ps_on | (st_d != kms_pkg::SC_IDLE);
      gpo_outputs      <= gpo_q & port_en(psel_q);
    end
  end

  // serial link: address in with enable low, key data out with it high
  assign read_done = ce_p & ~ce_s & rd_q;
  always_comb begin
    addr_d = addr_q;
    rd_d   = rd_q;
    shf_d  = shf_q;
    if (!ce_s && scl_s && !scl_p) begin
      addr_d = {sdi_s, addr_q[7:1]}; // lsb first
    end
    if (ce_s && !ce_p) begin
      rd_d  = (addr_q == kms_pkg::KEY_ADDR);
      shf_d = {ps_on, key_q};
    end else if (ce_s && rd_q && scl_p && !scl_s) begin
      shf_d = {1'b1, shf_q[NK:1]};
    end
    if (!ce_s && ce_p) rd_d = 1'b0;
    // pull low only: data zero while reading, or pending request
    if (ce_s) oe_d = rd_q & ~shf_q[0];
    else oe_d = (st_q == kms_pkg::SC_REQ);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p                     <= 1'b0;
      ce_p                      <= 1'b0;
      addr_q                    <= '0;
      rd_q                      <= 1'b0;
      shf_q                     <= '1;
      serial_out_key_request    <= 1'b0;
      serial_out_key_request_oe <= 1'b0;
    end else begin
      scl_p                     <= scl_s;
      ce_p                      <= ce_s;
      addr_q                    <= addr_d;
      rd_q                      <= rd_d;
      shf_q                     <= shf_d;
      serial_out_key_request    <= 1'b0;
      serial_out_key_request_oe <= oe_d;
    end
  end
endmodule

// ===== logic/kms_pkg.sv
// Purpose: shared constants and types of the key matrix scanner
// Assumes: one oscillator period per system clock unless retuned
// Notes:   timing figures are in oscillator periods
package kms_pkg;
  localparam int unsigned NUM_ROWS    = 6;
  localparam int unsigned NUM_COLS    = 5;
  localparam int unsigned NUM_KEYS    = 30;
  localparam logic [7:0]  KEY_ADDR    = 8'h43;
  // figures in oscillator periods
  localparam int unsigned SCAN_OSC    = 4608;
  localparam int unsigned REQ_OSC     = 9840;
  localparam int unsigned RESCAN_OSC  = 19680;
  localparam int unsigned CLK_PER_OSC = 1;
  localparam int unsigned SCAN_CYC    = SCAN_OSC * CLK_PER_OSC;
  localparam int unsigned REQ_CYC     = REQ_OSC * CLK_PER_OSC;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_KEYS    = 8'h08;
  // control word fields
  localparam int unsigned CTL_PS_LSB  = 0;
  localparam int unsigned CTL_PSEL_LSB = 3;
  localparam int unsigned CTL_GPO_LSB = 8;
  localparam logic [2:0]  PS_RST      = 3'h7;
  localparam logic [2:0]  PSEL_RST    = 3'h0;
  localparam logic [8:0]  GPO_RST     = 9'h000;
  // status word fields
  localparam int unsigned ST_ACK_BIT  = 0;
  localparam int unsigned ST_REQ_BIT  = 1;
  localparam int unsigned ST_BUSY_BIT = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    SC_IDLE = 4'b0001,
    SC_SCAN = 4'b0010,
    SC_TAIL = 4'b0100,
    SC_REQ  = 4'b1000
  } kms_state_t;
endpackage

// ===== logic/kms_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes:   output changes only when stages two and three agree
module kms_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] stable_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, st_d;

  // first stage feeds only the second
  always_comb begin
    st_d = stable_out;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) st_d[i] = s3_q[i];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q       <= '0;
      s2_q       <= '0;
      s3_q       <= '0;
      stable_out <= '0;
    end else begin
      s1_q       <= async_in;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      stable_out <= st_d;
    end
  end
endmodule

// ===== tb/kms_scanner_assertions.sv
// Purpose: port checks of the key matrix scanner
// Assumes: one clock domain with an asynchronous active-high reset
// Notes:   attached to every scanner instance by the bind below
module kms_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_out_key_request,
  input wire logic [5:0]  scan_row_outputs,
  input wire logic        lcd_outputs_off
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // open drain: the data side of the pin never carries a one
  chk_line_pull_low: assert property (serial_out_key_request == 1'b0)
    else $error("request line driven high");
  // normal mode rows idle high or strobe at most one row
  chk_rows_one_hot: assert property (
    !lcd_outputs_off && !$past(lcd_outputs_off) |->
    scan_row_outputs == 6'h3f || $onehot0(scan_row_outputs))
    else $error("scan rows neither idle high nor single");
  // reset leaves power save with every row held low
  chk_reset_ps: assert property (
    $past(sys_rst) |-> lcd_outputs_off && scan_row_outputs == 6'h00)
    else $error("power save not active after reset");
  // bus timing as fixed by the register slave
  chk_aw_answer: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_bvalid && !s_axi_awready |=>
    s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
    else $error("write not answered in time");
  chk_ar_answer: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid)
    else $error("read not answered in time");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_b_no_spurious: assert property (!s_axi_bvalid &&
    !(s_axi_awvalid && s_axi_wvalid) |=> !s_axi_bvalid)
    else $error("write response without request");
endmodule

bind kms_scanner kms_chk u_chk (.clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .serial_out_key_request, .scan_row_outputs,
  .lcd_outputs_off);

// ===== tb/kms_host_model.sv
// Purpose: host controller on the four-wire key read link
// Assumes: pull-up on the shared request and data line
// Notes:   link clock of 800 ns stands low between frames
module kms_host_model (
  input  wire logic line,
  output logic      link_clk,
  output logic      enable,
  output logic      data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_clk = 1'b0;
    enable = 1'b0;
    data = 1'b0;
  end
  // offset start keeps link edges clear of the system clock edges
  task automatic frame(input logic [7:0] addr, output logic [30:0] bits);
    #23;
    for (int i = 0; i < 8; i++) begin
      data = addr[i];
      #400 link_clk = 1'b1;
      #400 link_clk = 1'b0;
    end
    data = ~data;
    #400 enable = 1'b1;
    // bits change on the falling edge, so sample just before it
    for (int i = 0; i < 31; i++) begin
      #400 link_clk = 1'b1;
      #390 bits[i] = line;
      #10 link_clk = 1'b0;
    end
    #400 enable = 1'b0;
  endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the key matrix scanner
// Assumes: shortened scan counts, one oscillator period per clock
// Notes:   key matrix modelled here, link host in its own model
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SL = 60;
  localparam int unsigned RL = 130;
  typedef struct packed {
    logic [2:0]  ps;
    logic [29:0] keys;
  } kms_case_t;
  // corner keys, two rows at once, power-save wake on the last row
  kms_case_t   cases [4] = '{'{3'h0, 30'h1}, '{3'h0, 30'h20000000},
                             '{3'h0, 30'h1040}, '{3'h1, 30'h2000000}};
  logic [2:0]  psv [3] = '{3'h4, 3'h2, 3'h0};
  // rows left high per code: top rows for 1..6, all high in normal mode
  logic [5:0]  psr [3] = '{6'h3c, 6'h30, 6'h3f};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r2;
  logic [31:0] s_axi_rdata, d;
  logic        serial_clock_in, chip_enable_in, serial_data_in;
  logic        serial_out_key_request, serial_out_key_request_oe;
  logic        lcd_outputs_off, osc_running, line;
  logic [5:0]  scan_row_outputs;
  logic [4:0]  return_column_inputs = 5'h00;
  logic [8:0]  gpo_outputs;
  logic [29:0] pressed = 30'h0;
  logic [30:0] bits;
  int          error_cnt = 0, checked = 0, cyc = 0, n;

  kms_scanner #(.SCAN_LEN(SL), .REQ_LEN(RL)) dut (.clk, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_clock_in, .chip_enable_in, .serial_data_in,
    .serial_out_key_request, .serial_out_key_request_oe, .scan_row_outputs,
    .return_column_inputs, .lcd_outputs_off, .osc_running, .gpo_outputs);
  kms_host_model host (.line, .link_clk(serial_clock_in),
    .enable(chip_enable_in), .data(serial_data_in));

  // pull-up wins whenever the pin is released
  assign line = serial_out_key_request_oe ? serial_out_key_request : 1'b1;
  always #50 clk = ~clk;
  // key matrix: a column reads high when a pressed key sits on a high row
  always @(posedge clk) begin
    logic [4:0] c;
    c = 5'h00;
    for (int k = 0; k < 30; k++)
      if (pressed[k] && scan_row_outputs[k / 5]) c[k % 5] = 1'b1;
    return_column_inputs <= c;
  end
  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw |= (s_axi_awready === 1'b1);
      w |= (s_axi_wready === 1'b1);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_req(output int k);
    k = 0;
    while (line !== 1'b0 && k < 4 * RL) begin
      @(posedge clk);
      k++;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (cases[i]) begin
      wr(kms_pkg::OFS_CTRL, {29'h0, cases[i].ps}, r2);
      pressed <= cases[i].keys;
      wait_req(n);
      check("request delay", n >= RL && n <= 2 * RL + 20, 1);
      host.frame(8'h43, bits);
      @(posedge clk);
      pressed <= 30'h0;
      check("key bits", bits[29:0], cases[i].keys);
      check("ack bit", bits[30], |cases[i].ps);
      check("key count", $countones(bits[29:0]) < 3, 1);
      repeat (10) @(posedge clk);
      check("line after read", line, 1);
      rd(kms_pkg::OFS_STATUS, d, r2);
      check("status after read", d[2:0], {2'b10, |cases[i].ps});
      repeat (3 * RL) @(posedge clk);
    end
    // power save holds while any control bit is set
    foreach (psv[i]) begin
      wr(kms_pkg::OFS_CTRL, {29'h0, psv[i]}, r2);
      rd(kms_pkg::OFS_STATUS, d, r2);
      check("ack after write", d[0], psv[i] != 3'h0);
      check("lcd after write", lcd_outputs_off, psv[i] != 3'h0);
      check("osc after write", osc_running, psv[i] == 3'h0);
      check("rows after write", scan_row_outputs, psr[i]);
    end
    // a foreign address leaves the line released and the request pending
    pressed <= 30'h1;
    wait_req(n);
    host.frame(8'h12, bits);
    @(posedge clk);
    check("foreign frame", bits, 31'h7fffffff);
    repeat (10) @(posedge clk);
    check("request kept", line, 0);
    host.frame(8'h43, bits);
    @(posedge clk);
    pressed <= 30'h0;
    check("key after foreign", bits, {1'b0, 30'h1});
    // unmapped and read-only places
    wr(8'h0c, 32'h1, r2);
    check("unmapped bresp", r2, kms_pkg::RESP_SLVERR);
    rd(8'h0c, d, r2);
    check("unmapped rresp", r2, kms_pkg::RESP_SLVERR);
    check("unmapped data", d, 0);
    wr(kms_pkg::OFS_KEYS, 32'hffffffff, r2);
    check("keys write resp", r2, kms_pkg::RESP_OKAY);
    // full power save with the general-purpose ports still driven
    wr(kms_pkg::OFS_CTRL, 32'h0001ff17, r2);
    @(posedge clk);
    check("gpo partial", gpo_outputs, 9'h003);
    wr(kms_pkg::OFS_CTRL, 32'h0001a53f, r2);
    // let the rescan after the last read finish before the oscillator check
    repeat (2 * RL) @(posedge clk);
    check("gpo in power save", gpo_outputs, 9'h1a5);
    check("lcd blanked", lcd_outputs_off, 1);
    check("osc stopped", osc_running, 0);
    // reset in mid-run restores the power-save default
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("gpo reset", gpo_outputs, 0);
    rd(kms_pkg::OFS_CTRL, d, r2);
    check("ctrl reset", d, 32'h7);
    summarize();
  end
endmodule
